// ==== src/drsic_top.sv ====
/*
 * Run/stop/direction decoder for the control terminal block, with
 * reference source selection and preset speed lookup.
 * Assumes contact inputs are asynchronous pins, high meaning closed,
 * and that keypad command and programming ports are on clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drsic_consts.svh"

module drsic_top
	import drsic_pkg::*;
(
	input  wire logic                        clk,                    // 100 MHz clock
	input  wire logic                        rstn,                   // Async reset, low
	input  wire logic [2:0]                  control_method_select,  // Input mode 0..6
	input  wire logic                        preset_variant,         // 1 = preset model
	input  wire logic [1:0]                  frequency_source_parameter, // Source select
	input  wire drsic_pkg::drsic_freq_t      internal_frequency_setting, // Internal ref
	input  wire drsic_pkg::drsic_freq_t      pot_ref,                // Potentiometer ref
	input  wire drsic_pkg::drsic_freq_t      volt_ref,               // Bipolar volt ref
	input  wire drsic_pkg::drsic_freq_t      current_ref,            // Current loop ref
	input  wire drsic_pkg::drsic_freq_t      remote_ref,             // Remote reference
	input  wire logic                        use_presets,            // Preset vs internal
	input  wire logic                        rev_in,                 // Pin: reverse/run rev
	input  wire logic                        fwd_in,                 // Pin: start/run fwd
	input  wire logic                        stop_or_select_terminal,// Pin: stop/select
	input  wire logic                        preset_select_bit0,     // Pin: preset bit 0
	input  wire logic                        preset_select_bit1,     // Pin: preset bit 1
	input  wire logic                        preset_select_bit2,     // Pin: preset bit 2
	input  wire logic                        kp_start,               // Keypad start pulse
	input  wire logic                        kp_stop,                // Keypad stop pulse
	input  wire logic                        kp_rev,                 // Keypad direction
	input  wire logic                        kp_wr_en,               // Keypad preset write
	input  wire logic [2:0]                  kp_wr_addr,             // Preset index
	input  wire drsic_pkg::drsic_freq_t      kp_wr_data,             // Preset value
	output logic                             run,                    // Motor running
	output logic                             reverse,                // Direction reverse
	output logic                             coast,                  // Drive removed
	output logic                             accel_set2,             // Second ramp pair
	output logic                             remote_ctrl,            // Remote control
	output logic                             fault_clear,            // Fault clear pulse
	output drsic_pkg::drsic_freq_t           freq_ref                // Frequency reference
);
	// ------------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------------
	localparam int NC = `DRSIC_N_CONTACT;
	wire  [NC-1:0] raw_pins;           // Contact pins, closed high
	logic [NC-1:0] deb;                // Debounced levels
	assign raw_pins = {preset_select_bit2, preset_select_bit1, preset_select_bit0,
		stop_or_select_terminal, fwd_in, rev_in, 1'b0};

	// One synchroniser and debounce counter per contact
	genvar g;
	generate
		for (g = 0; g < NC; g++)
		begin : g_deb
			logic [2:0]             sy_r;   // Three-stage sync
			logic [`DRSIC_DEB_W-1:0] cnt_r; // Stable count
			logic                   lvl_r;  // Accepted level
			wire                    agree;  // Stages 2 and 3 agree
			wire                    differ; // Accepted level stale
			assign agree  = (sy_r[1] == sy_r[2]);
			assign differ = agree && (sy_r[2] != lvl_r);
			// Sync, then accept after a stable interval
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
				begin
					sy_r  <= 3'h0;
					cnt_r <= '0;
					lvl_r <= 1'b0;
				end
				else
				begin
					sy_r <= {sy_r[1:0], raw_pins[g]};
					if (!differ)
						cnt_r <= '0;
					else if (cnt_r == `DRSIC_DEB_W'(`DRSIC_DEB_CYCLES - 1))
					begin
						lvl_r <= sy_r[2];
						cnt_r <= '0;
					end
					else
						cnt_r <= cnt_r + `DRSIC_DEB_W'(1);
				end
			end
			assign deb[g] = lvl_r;
		end
	endgenerate

	// Named debounced contacts
	wire c_rev  = deb[1];   // Reverse / run reverse
	wire c_fwd  = deb[2];   // Start / run forward
	wire c_sel  = deb[3];   // Stop or select terminal
	wire [2:0] c_preset = deb[6:4];  // Preset index

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	function automatic logic is_mode(input logic [2:0] m, input logic [2:0] v);
		is_mode = (m == v);
	endfunction

	logic [2:0] mode_r;  // Sampled method select
	// Out of range values fall back to the default method
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			mode_r <= `DRSIC_MODE_RESET;
		else if (control_method_select <= `DRSIC_MODE_LOCAL_REM)
			mode_r <= control_method_select;
		else
			mode_r <= `DRSIC_MODE_RESET;
	end

	wire m_three  = is_mode(mode_r, `DRSIC_MODE_THREE_WIRE);
	wire m_keypad = is_mode(mode_r, `DRSIC_MODE_KEYPAD);
	wire m_mom    = is_mode(mode_r, `DRSIC_MODE_MOMENTARY);
	wire m_accel  = is_mode(mode_r, `DRSIC_MODE_ACCEL_SEL);
	wire m_enab   = is_mode(mode_r, `DRSIC_MODE_ENABLE);
	wire m_locrem = is_mode(mode_r, `DRSIC_MODE_LOCAL_REM);
	wire m_sel    = m_accel | m_enab | m_locrem;       // Terminal is a select
	wire m_maint  = ~m_three & ~m_keypad & ~m_mom;     // Maintained two-wire
	wire stop_ok  = m_sel | c_sel;                     // Stop contact closed, or terminal is a select

	// ------------------------------------------------------------------
	// Toggle tracking: a run input must be seen open after a stop
	// ------------------------------------------------------------------
	drsic_run_t st_r;       // Run state
	drsic_run_t st_nxt;     // Next run state
	logic       fwd_arm_r;  // Forward seen open since stop
	logic       rev_arm_r;  // Reverse seen open since stop
	wire        stopping = (st_r != DRSIC_STOPPED) && (st_nxt == DRSIC_STOPPED);
	// Arm on open, disarm on stop; open seen in the stop cycle still arms
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fwd_arm_r <= 1'b0;
			rev_arm_r <= 1'b0;
		end
		else
		begin
			fwd_arm_r <= !c_fwd || (fwd_arm_r && !stopping);
			rev_arm_r <= !c_rev || (rev_arm_r && !stopping);
		end
	end
	wire fwd_fresh = c_fwd && fwd_arm_r;  // Fresh forward closure
	wire rev_fresh = c_rev && rev_arm_r;  // Fresh reverse closure

	// ------------------------------------------------------------------
	// Run state machine
	// ------------------------------------------------------------------
	logic enable_ok;  // Mode 5 enable closed
	assign enable_ok = !m_enab || c_sel;
	logic kp_rev_r;   // Keypad direction latch

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			DRSIC_STOPPED:
			begin
				if (m_keypad)
				begin
					if (kp_start && !kp_stop)
						st_nxt = kp_rev ? DRSIC_RUN_REV : DRSIC_RUN_FWD;
				end
				else if (m_three)
				begin
					if (stop_ok && fwd_fresh)
						st_nxt = c_rev ? DRSIC_RUN_REV : DRSIC_RUN_FWD;
				end
				else if (m_mom)
				begin
					if (stop_ok && c_fwd)
						st_nxt = DRSIC_RUN_FWD;
					else if (stop_ok && c_rev)
						st_nxt = DRSIC_RUN_REV;
				end
				else if (stop_ok && enable_ok)
				begin
					if (fwd_fresh)
						st_nxt = DRSIC_RUN_FWD;
					else if (rev_fresh)
						st_nxt = DRSIC_RUN_REV;
				end
			end
			DRSIC_RUN_FWD, DRSIC_RUN_REV:
			begin
				if (m_keypad)
				begin
					if (kp_stop)
						st_nxt = DRSIC_STOPPED;
				end
				else if (!stop_ok)
					st_nxt = DRSIC_STOPPED;
				else if (m_three)
					st_nxt = c_rev ? DRSIC_RUN_REV : DRSIC_RUN_FWD;
				else if (m_mom)
				begin
					if (c_fwd)
						st_nxt = DRSIC_RUN_FWD;
					else if (c_rev)
						st_nxt = DRSIC_RUN_REV;
				end
				else if (!enable_ok)
					st_nxt = DRSIC_STOPPED;
				else if (st_r == DRSIC_RUN_FWD && !c_fwd)
					st_nxt = c_rev ? DRSIC_RUN_REV : DRSIC_STOPPED;
				else if (st_r == DRSIC_RUN_REV && !c_rev)
					st_nxt = c_fwd ? DRSIC_RUN_FWD : DRSIC_STOPPED;
			end
			default:
				st_nxt = DRSIC_STOPPED;
		endcase
	end

	// State and keypad direction registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r     <= DRSIC_STOPPED;
			kp_rev_r <= 1'b0;
		end
		else
		begin
			st_r     <= st_nxt;
			kp_rev_r <= kp_rev;
		end
	end

	// ------------------------------------------------------------------
	// Select terminal functions and fault clear
	// ------------------------------------------------------------------
	logic sel_d_r;  // Previous select level
	wire  sel_edge = m_sel && (c_sel != sel_d_r);

	// Registered control outputs
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sel_d_r     <= 1'b0;
			run         <= 1'b0;
			reverse     <= 1'b0;
			coast       <= 1'b1;
			accel_set2  <= 1'b0;
			remote_ctrl <= 1'b0;
			fault_clear <= 1'b0;
		end
		else
		begin
			sel_d_r     <= c_sel;
			run         <= (st_nxt != DRSIC_STOPPED);
			reverse     <= (st_nxt == DRSIC_RUN_REV);
			coast       <= (st_nxt == DRSIC_STOPPED) || !enable_ok;
			accel_set2  <= m_accel && !c_sel;
			remote_ctrl <= m_locrem && c_sel;
			fault_clear <= sel_edge;
		end
	end

	// ------------------------------------------------------------------
	// Frequency reference
	// ------------------------------------------------------------------
	drsic_freq_t preset_q;  // Registered preset word
	drsic_preset_mem u_mem (
		.clk     (clk),
		.rstn    (rstn),
		.wr_en   (kp_wr_en),
		.wr_addr (kp_wr_addr),
		.wr_data (kp_wr_data),
		.rd_addr (c_preset),
		.rd_data (preset_q)
	);

	drsic_freq_t analog_sel;  // Chosen analog source
	drsic_freq_t term_ref;    // Terminal block reference
	drsic_freq_t ref_nxt;     // Final reference
	assign analog_sel =
		(frequency_source_parameter == `DRSIC_SRC_POT)     ? pot_ref :
		(frequency_source_parameter == `DRSIC_SRC_VOLT)    ? volt_ref :
		(frequency_source_parameter == `DRSIC_SRC_CURRENT) ? current_ref :
		internal_frequency_setting;
	assign term_ref = preset_variant ?
		(use_presets ? preset_q : internal_frequency_setting) :
		analog_sel;
	// Mode 6 closed selects remote; open forces terminal reference
	assign ref_nxt = (m_locrem && c_sel) ? remote_ref : term_ref;

	// Registered reference output
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			freq_ref <= '0;
		else
			freq_ref <= ref_nxt;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_three_stop_halt: assert property (@(posedge clk) disable iff (!rstn)
		(m_three && !c_sel && !$changed(mode_r)) |=> !run)
		else $error("Three-wire run with open stop");
	a_three_toggle: assert property (@(posedge clk) disable iff (!rstn)
		(m_three && st_r == DRSIC_STOPPED && !fwd_arm_r) |=> !run)
		else $error("Three-wire restart without toggle");
	a_two_held: assert property (@(posedge clk) disable iff (!rstn)
		(mode_r == `DRSIC_MODE_TWO_WIRE && !c_fwd && !c_rev) |=> !run)
		else $error("Two-wire run with inputs open");
	a_two_fresh: assert property (@(posedge clk) disable iff (!rstn)
		(m_maint && st_r == DRSIC_STOPPED && !fwd_arm_r && !rev_arm_r) |=> !run)
		else $error("Two-wire restart without fresh closure");
	a_mom_resume: assert property (@(posedge clk) disable iff (!rstn)
		(m_mom && $past(m_mom) && c_sel && c_fwd) |=> run)
		else $error("Momentary did not resume");
	a_accel_pair: assert property (@(posedge clk) disable iff (!rstn)
		(m_accel ##1 m_accel) |-> (accel_set2 == !$past(c_sel)))
		else $error("Ramp pair select wrong");
	a_enable_coast: assert property (@(posedge clk) disable iff (!rstn)
		(m_enab && !c_sel) |=> (coast && !run))
		else $error("Enable open but not coasting");
	a_fault_edge: assert property (@(posedge clk) disable iff (!rstn)
		fault_clear |-> $past(m_sel) && ($past(c_sel) != $past(sel_d_r)))
		else $error("Fault clear without select edge");
	a_mode_reset: assert property (@(posedge clk) disable iff (!rstn)
		(control_method_select > `DRSIC_MODE_LOCAL_REM) |=> m_three)
		else $error("Bad mode not defaulted");
endmodule // drsic_top
`default_nettype wire

// ==== src/drsic_consts.svh ====
/*
 * Constants for the run/stop input control block: mode codes, reference
 * source codes, debounce timing, preset count and reset values.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef DRSIC_CONSTS_SVH
`define DRSIC_CONSTS_SVH

// ----------------------------------------------------------------------
// Control method select codes
// ----------------------------------------------------------------------
`define DRSIC_MODE_THREE_WIRE  3'h0
`define DRSIC_MODE_TWO_WIRE    3'h1
`define DRSIC_MODE_KEYPAD      3'h2
`define DRSIC_MODE_MOMENTARY   3'h3
`define DRSIC_MODE_ACCEL_SEL   3'h4
`define DRSIC_MODE_ENABLE      3'h5
`define DRSIC_MODE_LOCAL_REM   3'h6
`define DRSIC_MODE_RESET       3'h0

// ----------------------------------------------------------------------
// Reference source codes
// ----------------------------------------------------------------------
`define DRSIC_SRC_INTERNAL     2'h0
`define DRSIC_SRC_POT          2'h1
`define DRSIC_SRC_VOLT         2'h2
`define DRSIC_SRC_CURRENT      2'h3

// ----------------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------------
`define DRSIC_DEB_TIME_NS      1000
`define DRSIC_CLK_PERIOD_NS    10
`define DRSIC_DEB_CYCLES       (`DRSIC_DEB_TIME_NS / `DRSIC_CLK_PERIOD_NS)
`define DRSIC_DEB_W            7
`define DRSIC_N_PRESET         8
`define DRSIC_PRESET_AW        3
`define DRSIC_FREQ_W           16
`define DRSIC_N_CONTACT        7

`endif

// ==== src/drsic_pkg.sv ====
/*
 * Types for the run/stop input control block.
 * Assumes the constants header is compiled alongside.
 */
package drsic_pkg;
	// Run state of the start/stop decoder
	typedef enum logic [1:0] {
		DRSIC_STOPPED,
		DRSIC_RUN_FWD,
		DRSIC_RUN_REV
	} drsic_run_t;
	// Frequency word
	typedef logic [15:0] drsic_freq_t;
endpackage : drsic_pkg

// ==== src/drsic_preset_mem.sv ====
/*
 * Eight-entry preset frequency store with registered read data.
 * Assumes writes come only from the keypad programming port.
 */
`timescale 1ns/10ps
`default_nettype none
`include "drsic_consts.svh"

module drsic_preset_mem
	import drsic_pkg::*;
(
	input  wire logic                          clk,       // System clock
	input  wire logic                          rstn,      // Async reset, low
	input  wire logic                          wr_en,     // Keypad write strobe
	input  wire logic [`DRSIC_PRESET_AW-1:0]   wr_addr,   // Keypad write index
	input  wire drsic_pkg::drsic_freq_t        wr_data,   // Keypad write value
	input  wire logic [`DRSIC_PRESET_AW-1:0]   rd_addr,   // Preset index
	output drsic_pkg::drsic_freq_t             rd_data    // Registered preset
);
	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	drsic_freq_t mem_r [`DRSIC_N_PRESET];  // Preset words

	// Keypad writes; defaults are the reset contents
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < `DRSIC_N_PRESET; i++)
				mem_r[i] <= '0;
		end
		else if (wr_en)
			mem_r[wr_addr] <= wr_data;
	end

	// Registered read
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rd_data <= '0;
		else
			rd_data <= mem_r[rd_addr];
	end
endmodule // drsic_preset_mem
`default_nettype wire

// ==== verif/drsic_field.sv ====
/*
 * Model of the field contacts wired to the control terminal block.
 * Assumes high on a pin means a closed contact and open pulls low.
 */
`timescale 1ns/10ps
`default_nettype none

module drsic_field
(
	input  wire logic       fwd_cmd,  // Forward/start contact wanted
	input  wire logic       rev_cmd,  // Reverse contact wanted
	input  wire logic       stop_cmd, // Stop/select contact closed
	input  wire logic [2:0] sel_cmd,  // Preset switch contacts
	output logic            fwd_in,   // Pin: start/run forward
	output logic            rev_in,   // Pin: reverse/run reverse
	output logic            stop_pin, // Pin: stop/select
	output logic [2:0]      sel_pin   // Pins: preset bits
);
	// ----------------------------------------------------------------
	// Contact levels
	// ----------------------------------------------------------------
	// Open contacts read low through the pull-down
	assign fwd_in = fwd_cmd;
	// Reverse is held off while forward is closed
	assign rev_in = rev_cmd & ~fwd_cmd;
	// Maintained stop contact
	assign stop_pin = stop_cmd;
	// Preset switches as plain contacts
	assign sel_pin = sel_cmd;
endmodule // drsic_field

`default_nettype wire

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the run/stop input control block.
 * Assumes the design package and the contact model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
	import drsic_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk, rstn, preset_variant, use_presets;
	logic [2:0]  control_method_select, kp_wr_addr, sel_cmd;
	logic [1:0]  frequency_source_parameter;
	drsic_freq_t internal_frequency_setting, pot_ref, volt_ref, current_ref;
	drsic_freq_t remote_ref, kp_wr_data, freq_ref;
	logic        kp_start, kp_stop, kp_rev, kp_wr_en;
	logic        fwd_cmd, rev_cmd, stop_cmd, rev_in, fwd_in;
	logic        stop_or_select_terminal;
	logic        preset_select_bit0, preset_select_bit1, preset_select_bit2;
	logic        run, reverse, coast, accel_set2, remote_ctrl, fault_clear;
	int          n_errors, tests_run, cycles, fc_count, fc0;

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	drsic_field i_drsic_field (.fwd_cmd, .rev_cmd, .stop_cmd, .sel_cmd,
		.fwd_in, .rev_in, .stop_pin(stop_or_select_terminal),
		.sel_pin({preset_select_bit2, preset_select_bit1, preset_select_bit0}));
	drsic_top i_drsic_top (.clk, .rstn, .control_method_select, .preset_variant,
		.frequency_source_parameter, .internal_frequency_setting, .pot_ref,
		.volt_ref, .current_ref, .remote_ref, .use_presets, .rev_in, .fwd_in,
		.stop_or_select_terminal, .preset_select_bit0, .preset_select_bit1,
		.preset_select_bit2, .kp_start, .kp_stop, .kp_rev, .kp_wr_en,
		.kp_wr_addr, .kp_wr_data, .run, .reverse, .coast, .accel_set2,
		.remote_ctrl, .fault_clear, .freq_ref);

	// ----------------------------------------------------------------
	// Clock, timeout and pulse counting
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Counts fault clear pulses and cuts a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (fault_clear === 1'b1)
			fc_count++;
		if (cycles == 20000)
		begin
			n_errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compares one value and counts it
	task automatic check(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Waits out synchroniser, debounce and output register
	task automatic settle();
		repeat (120) @(negedge clk);
	endtask
	// Sets the mode and lets it register
	task automatic mode(input logic [2:0] m);
		control_method_select = m;
		repeat (3) @(negedge clk);
	endtask
	// One keypad pulse
	task automatic kp_pulse(input bit start);
		if (start)
			kp_start = 1'b1;
		else
			kp_stop = 1'b1;
		@(negedge clk);
		kp_start = 1'b0;
		kp_stop = 1'b0;
		@(negedge clk);
	endtask
	// Prints the verdict and ends the run
	task automatic results();
		if (n_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		n_errors = 0; tests_run = 0; cycles = 0; fc_count = 0;
		rstn = 1'b0; control_method_select = 3'h0; preset_variant = 1'b0;
		use_presets = 1'b0; frequency_source_parameter = 2'h0;
		internal_frequency_setting = 16'h1a2b; pot_ref = 16'h2c3d;
		volt_ref = 16'h3e4f; current_ref = 16'h4a5b; remote_ref = 16'h5c6d;
		kp_start = 1'b0; kp_stop = 1'b0; kp_rev = 1'b0; kp_wr_en = 1'b0;
		kp_wr_addr = 3'h0; kp_wr_data = 16'h0; sel_cmd = 3'h0;
		fwd_cmd = 1'b0; rev_cmd = 1'b0; stop_cmd = 1'b0;
		repeat (16) @(negedge clk);
		check("rst run", run, 1'b0);
		check("rst coast", coast, 1'b1);
		check("rst freq", freq_ref, 16'h0);
		rstn = 1'b1;
		// Three-wire: stop closed, start closed
		stop_cmd = 1'b1; settle();
		fwd_cmd = 1'b1; settle();
		check("m0 run", run, 1'b1);
		check("m0 dir", reverse, 1'b0);
		stop_cmd = 1'b0; repeat (50) @(negedge clk); stop_cmd = 1'b1; settle();
		check("glitch", run, 1'b1);
		stop_cmd = 1'b0; settle();
		check("m0 stop", run, 1'b0);
		stop_cmd = 1'b1; settle();
		check("m0 held", run, 1'b0);
		fwd_cmd = 1'b0; settle(); fwd_cmd = 1'b1; settle();
		check("m0 toggle", run, 1'b1);
		stop_cmd = 1'b0; fwd_cmd = 1'b0; settle();
		// Two-wire run forward/reverse
		mode(3'h1); stop_cmd = 1'b1; settle();
		rev_cmd = 1'b1; settle();
		check("m1 rev run", run, 1'b1);
		check("m1 rev dir", reverse, 1'b1);
		rev_cmd = 1'b0; settle();
		check("m1 rev off", run, 1'b0);
		fwd_cmd = 1'b1; settle();
		check("m1 fwd dir", reverse, 1'b0);
		stop_cmd = 1'b0; settle(); stop_cmd = 1'b1; settle();
		check("m1 held", run, 1'b0);
		fwd_cmd = 1'b0; settle(); fwd_cmd = 1'b1; settle();
		check("m1 fresh", run, 1'b1);
		fwd_cmd = 1'b0; settle();
		// Momentary run
		mode(3'h3);
		fwd_cmd = 1'b1; repeat (150) @(negedge clk); fwd_cmd = 1'b0; settle();
		check("m3 latch", run, 1'b1);
		fwd_cmd = 1'b1; settle(); stop_cmd = 1'b0; settle();
		check("m3 stop", run, 1'b0);
		stop_cmd = 1'b1; settle();
		check("m3 resume", run, 1'b1);
		stop_cmd = 1'b0; fwd_cmd = 1'b0; settle();
		// Keypad control ignores the terminal
		mode(3'h2); stop_cmd = 1'b1; fwd_cmd = 1'b1; settle();
		check("m2 pins", run, 1'b0);
		fwd_cmd = 1'b0; kp_rev = 1'b1; kp_pulse(1'b1);
		check("m2 start", run, 1'b1);
		check("m2 dir", reverse, 1'b1);
		kp_pulse(1'b0);
		check("m2 stop", run, 1'b0);
		kp_rev = 1'b0;
		// Ramp pair select and fault clear
		mode(3'h4); stop_cmd = 1'b0; settle();
		check("m4 open", accel_set2, 1'b1);
		fc0 = fc_count; stop_cmd = 1'b1; settle();
		check("m4 closed", accel_set2, 1'b0);
		check("m4 fclr", 16'(fc_count - fc0), 16'h1);
		// Enable terminal
		mode(3'h5); fwd_cmd = 1'b1; settle();
		check("m5 run", run, 1'b1);
		check("m5 drive", coast, 1'b0);
		stop_cmd = 1'b0; settle();
		check("m5 coast", coast, 1'b1);
		check("m5 halt", run, 1'b0);
		fwd_cmd = 1'b0; stop_cmd = 1'b1; settle();
		// Local/remote select
		mode(3'h6); settle();
		check("m6 remote", remote_ctrl, 1'b1);
		check("m6 rref", freq_ref, remote_ref);
		stop_cmd = 1'b0; settle();
		check("m6 local", remote_ctrl, 1'b0);
		check("m6 tref", freq_ref, internal_frequency_setting);
		// One reference source at a time; out-of-range mode falls back to 0
		mode(3'h7);
		check("m7 run", run, 1'b0);
		for (int s = 0; s < 4; s++)
		begin
			frequency_source_parameter = 2'(s); repeat (3) @(negedge clk);
			check("source", freq_ref, s == 0 ? internal_frequency_setting :
				s == 1 ? pot_ref : s == 2 ? volt_ref : current_ref);
		end
		// Preset table written from the keypad
		preset_variant = 1'b1; use_presets = 1'b1;
		kp_wr_addr = 3'h5; kp_wr_data = 16'hbeef; kp_wr_en = 1'b1;
		@(negedge clk); kp_wr_en = 1'b0;
		sel_cmd = 3'h5; settle();
		check("preset 5", freq_ref, 16'hbeef);
		sel_cmd = 3'h2; settle();
		check("preset 2", freq_ref, 16'h0);
		use_presets = 1'b0; repeat (3) @(negedge clk);
		check("preset int", freq_ref, internal_frequency_setting);
		results();
	end
endmodule // tb

`default_nettype wire
